/* design/rtcal_top.sv */
// Alarm compare, repeat counting, alarm pulse and per-minute calibration of a
// real-time clock, with its registers on an Avalon-MM slave.
// Assumes the time counters run on clk and give one-cycle ticks on clk.
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rtcal_params.svh"

module rtcal_top
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire rtcal_pkg::rtcal_time_t time_now,
    input wire logic half_sec_tick,
    input wire logic second_tick,
    input wire logic minute_tick,
    output logic alarm_irq,
    output logic alarm_pulse,
    output logic cal_add_pulse,
    output logic cal_sub_pulse
);

    // ------------------------------------------------------------
    // State and bus request
    // ------------------------------------------------------------

    rtcal_pkg::rtcal_state_t st;
    rtcal_pkg::rtcal_state_t next_st;
    rtcal_pkg::rtcal_avs_req_t req;
    rtcal_pkg::rtcal_time_t alarm_time;
    logic request;
    logic take;
    logic [7:0] need;
    logic [7:0] equal;
    logic alarm_hit;
    logic alarm_fire;
    logic [8:0] cal_magnitude;
    logic [10:0] cal_count;

    assign req.address = avs_address;
    assign req.read = avs_read;
    assign req.write = avs_write;
    assign req.writedata = avs_writedata;
    assign req.byteenable = avs_byteenable;

    // The first cycle of a request only holds the bus; the answer comes in
    // the second, so decode and read data settle a full cycle ahead.
    assign request = req.read | req.write;
    assign take = request & st.ack;
    assign avs_waitrequest = request & ~st.ack;

    assign avs_readdata = st.readdata;
    assign alarm_irq = st.alarm_event;
    assign alarm_pulse = st.alarm_pulse;
    assign cal_add_pulse = st.cal_add;
    assign cal_sub_pulse = st.cal_sub;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    function automatic logic [15:0] merge_lanes(
        input logic [15:0] old_value,
        input logic [31:0] data,
        input logic [3:0] lanes,
        input logic [15:0] keep
    );
        logic [15:0] value;
        value = old_value;
        if (lanes[0])
        begin
            value[7:0] = data[7:0];
        end
        if (lanes[1])
        begin
            value[15:8] = data[15:8];
        end
        merge_lanes = value & keep;
    endfunction

    // ------------------------------------------------------------
    // Alarm compare
    // ------------------------------------------------------------

    assign alarm_time.month_tens_digit = st.alarm_month_day[12];
    assign alarm_time.month_ones_digit = st.alarm_month_day[11:8];
    assign alarm_time.day_tens_digit = st.alarm_month_day[5:4];
    assign alarm_time.day_ones_digit = st.alarm_month_day[3:0];
    assign alarm_time.weekday_digit = st.alarm_weekday_hours[10:8];
    assign alarm_time.hour_tens_digit = st.alarm_weekday_hours[5:4];
    assign alarm_time.hour_ones_digit = st.alarm_weekday_hours[3:0];
    assign alarm_time.minute_tens_digit = st.alarm_minutes_seconds[14:12];
    assign alarm_time.minute_ones_digit = st.alarm_minutes_seconds[11:8];
    assign alarm_time.second_tens_digit = st.alarm_minutes_seconds[6:4];
    assign alarm_time.second_ones_digit = st.alarm_minutes_seconds[3:0];

    always_comb
    begin
        equal[0] = alarm_time.second_ones_digit == time_now.second_ones_digit;
        equal[1] = alarm_time.second_tens_digit == time_now.second_tens_digit;
        equal[2] = alarm_time.minute_ones_digit == time_now.minute_ones_digit;
        equal[3] = alarm_time.minute_tens_digit == time_now.minute_tens_digit;
        equal[4] = (alarm_time.hour_tens_digit == time_now.hour_tens_digit)
            && (alarm_time.hour_ones_digit == time_now.hour_ones_digit);
        equal[5] = alarm_time.weekday_digit == time_now.weekday_digit;
        equal[6] = (alarm_time.day_tens_digit == time_now.day_tens_digit)
            && (alarm_time.day_ones_digit == time_now.day_ones_digit);
        equal[7] = (alarm_time.month_tens_digit == time_now.month_tens_digit)
            && (alarm_time.month_ones_digit == time_now.month_ones_digit);
    end

    // From ten seconds up, each wider interval adds digits to the compare; week adds the weekday,
    // while month and year use the day of month instead.
    always_comb
    begin
        need = 8'h00;
        alarm_hit = 1'b0;
        case (st.alarm_config_repeat[13:10])
            `RTCAL_ALARM_INTERVAL_MASK_HALF_SEC:
            begin
                alarm_hit = half_sec_tick;
            end
            `RTCAL_ALARM_INTERVAL_MASK_SECOND:
            begin
                alarm_hit = half_sec_tick & second_tick;
            end
            `RTCAL_ALARM_INTERVAL_MASK_TEN_SEC:
            begin
                need = 8'h01;
                alarm_hit = half_sec_tick & second_tick;
            end
            `RTCAL_ALARM_INTERVAL_MASK_MINUTE:
            begin
                need = 8'h03;
                alarm_hit = half_sec_tick & second_tick;
            end
            `RTCAL_ALARM_INTERVAL_MASK_TEN_MIN:
            begin
                need = 8'h07;
                alarm_hit = half_sec_tick & second_tick;
            end
            `RTCAL_ALARM_INTERVAL_MASK_HOUR:
            begin
                need = 8'h0f;
                alarm_hit = half_sec_tick & second_tick;
            end
            `RTCAL_ALARM_INTERVAL_MASK_DAY:
            begin
                need = 8'h1f;
                alarm_hit = half_sec_tick & second_tick;
            end
            `RTCAL_ALARM_INTERVAL_MASK_WEEK:
            begin
                need = 8'h3f;
                alarm_hit = half_sec_tick & second_tick;
            end
            `RTCAL_ALARM_INTERVAL_MASK_MONTH:
            begin
                need = 8'h5f;
                alarm_hit = half_sec_tick & second_tick;
            end
            `RTCAL_ALARM_INTERVAL_MASK_YEAR:
            begin
                need = 8'hdf;
                alarm_hit = half_sec_tick & second_tick;
            end
            default:
            begin
                need = 8'h00;
                alarm_hit = 1'b0;
            end
        endcase
    end

    // A tick lasts one cycle, so a match yields exactly one event.
    assign alarm_fire = st.alarm_config_repeat[`RTCAL_BIT_ALARM_ENABLE]
        & alarm_hit & (&(~need | equal));

    // ------------------------------------------------------------
    // Calibration amount
    // ------------------------------------------------------------

    always_comb
    begin
        if (st.clock_config_calibration[7])
        begin
            cal_magnitude = 9'h000 - {1'b1, st.clock_config_calibration[7:0]};
        end
        else
        begin
            cal_magnitude = {1'b0, st.clock_config_calibration[7:0]};
        end
        cal_count = {cal_magnitude, 2'b00};
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    always_comb
    begin
        next_st = st;
        next_st.ack = request & ~st.ack;
        next_st.alarm_event = 1'b0;
        next_st.cal_add = 1'b0;
        next_st.cal_sub = 1'b0;

        if (request & ~st.ack)
        begin
            next_st.readdata = 32'h0000_0000;
            if (req.read)
            begin
                if (req.address == `RTCAL_OFS_MONTH_DAY)
                begin
                    next_st.readdata = {16'h0000, st.alarm_month_day};
                end
                else if (req.address == `RTCAL_OFS_WEEKDAY_HOURS)
                begin
                    next_st.readdata = {16'h0000, st.alarm_weekday_hours};
                end
                else if (req.address == `RTCAL_OFS_MINUTES_SECONDS)
                begin
                    next_st.readdata = {16'h0000, st.alarm_minutes_seconds};
                end
                else if (req.address == `RTCAL_OFS_CONFIG_REPEAT)
                begin
                    next_st.readdata = {16'h0000, st.alarm_config_repeat};
                end
                else if (req.address == `RTCAL_OFS_CONFIG_CAL)
                begin
                    next_st.readdata = {16'h0000, st.clock_config_calibration};
                end
                else if (req.address == `RTCAL_OFS_STATUS)
                begin
                    next_st.readdata = {30'h0000_0000,
                        st.cal_state == rtcal_pkg::RTCAL_CAL_RUN, st.alarm_pulse};
                end
            end
        end

        // Writes land at the edge that answers the request.
        if (take & req.write)
        begin
            if (req.address == `RTCAL_OFS_MONTH_DAY)
            begin
                if (st.clock_config_calibration[`RTCAL_BIT_WRITE_ENABLE])
                begin
                    next_st.alarm_month_day = merge_lanes(st.alarm_month_day,
                        req.writedata, req.byteenable, `RTCAL_MASK_MONTH_DAY);
                end
            end
            else if (req.address == `RTCAL_OFS_WEEKDAY_HOURS)
            begin
                if (st.clock_config_calibration[`RTCAL_BIT_WRITE_ENABLE])
                begin
                    next_st.alarm_weekday_hours = merge_lanes(st.alarm_weekday_hours,
                        req.writedata, req.byteenable, `RTCAL_MASK_WEEKDAY_HOURS);
                end
            end
            else if (req.address == `RTCAL_OFS_MINUTES_SECONDS)
            begin
                next_st.alarm_minutes_seconds = merge_lanes(st.alarm_minutes_seconds,
                    req.writedata, req.byteenable, `RTCAL_MASK_MINUTES_SECONDS);
            end
            else if (req.address == `RTCAL_OFS_CONFIG_REPEAT)
            begin
                next_st.alarm_config_repeat = merge_lanes(st.alarm_config_repeat,
                    req.writedata, req.byteenable, `RTCAL_MASK_CONFIG_REPEAT);
            end
            else if (req.address == `RTCAL_OFS_CONFIG_CAL)
            begin
                next_st.clock_config_calibration = merge_lanes(
                    st.clock_config_calibration, req.writedata, req.byteenable,
                    `RTCAL_MASK_CONFIG_CAL);
            end
        end

        // An alarm in the same cycle as a configuration write overrides the
        // enable and count fields, so the hardware count step is never lost.
        if (alarm_fire)
        begin
            next_st.alarm_event = 1'b1;
            next_st.alarm_pulse = ~st.alarm_pulse;
            if (st.alarm_config_repeat[7:0] != 8'h00)
            begin
                next_st.alarm_config_repeat[7:0] =
                    st.alarm_config_repeat[7:0] - 8'h01;
                next_st.alarm_config_repeat[`RTCAL_BIT_ALARM_ENABLE] = 1'b1;
            end
            else if (st.alarm_config_repeat[`RTCAL_BIT_REPEAT_FOREVER])
            begin
                next_st.alarm_config_repeat[7:0] = `RTCAL_RPT_MAX;
                next_st.alarm_config_repeat[`RTCAL_BIT_ALARM_ENABLE] = 1'b1;
            end
            else
            begin
                next_st.alarm_config_repeat[7:0] = 8'h00;
                next_st.alarm_config_repeat[`RTCAL_BIT_ALARM_ENABLE] = 1'b0;
            end
        end

        // The amount is caught at the minute tick, so a later write to the
        // calibration field cannot disturb a burst already under way.
        case (st.cal_state)
            rtcal_pkg::RTCAL_CAL_IDLE:
            begin
                if (minute_tick && (cal_count != 11'h000))
                begin
                    next_st.cal_state = rtcal_pkg::RTCAL_CAL_RUN;
                    next_st.cal_left = cal_count[9:0];
                    next_st.cal_negative = st.clock_config_calibration[7];
                end
            end
            rtcal_pkg::RTCAL_CAL_RUN:
            begin
                next_st.cal_add = ~st.cal_negative;
                next_st.cal_sub = st.cal_negative;
                next_st.cal_left = st.cal_left - 10'h001;
                if (st.cal_left == 10'h001)
                begin
                    next_st.cal_state = rtcal_pkg::RTCAL_CAL_IDLE;
                end
            end
            default:
            begin
                next_st.cal_state = rtcal_pkg::RTCAL_CAL_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st.alarm_month_day <= `RTCAL_RESET_VALUE;
            st.alarm_weekday_hours <= `RTCAL_RESET_VALUE;
            st.alarm_minutes_seconds <= `RTCAL_RESET_VALUE;
            st.alarm_config_repeat <= `RTCAL_RESET_VALUE;
            st.clock_config_calibration <= `RTCAL_RESET_VALUE;
            st.ack <= 1'b0;
            st.readdata <= 32'h0000_0000;
            st.alarm_event <= 1'b0;
            st.alarm_pulse <= 1'b0;
            st.cal_state <= rtcal_pkg::RTCAL_CAL_IDLE;
            st.cal_left <= 10'h000;
            st.cal_negative <= 1'b0;
            st.cal_add <= 1'b0;
            st.cal_sub <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule // rtcal_top
`default_nettype wire

/* design/rtcal_params.svh */
// Offsets, field positions, reset values and codes of the alarm and calibration block.
// Assumes a byte-addressed register bus with one aligned 32-bit word per register.
`ifndef RTCAL_PARAMS_SVH
`define RTCAL_PARAMS_SVH
`define RTCAL_OFS_MONTH_DAY 5'h00
`define RTCAL_OFS_WEEKDAY_HOURS 5'h04
`define RTCAL_OFS_MINUTES_SECONDS 5'h08
`define RTCAL_OFS_CONFIG_REPEAT 5'h0c
`define RTCAL_OFS_CONFIG_CAL 5'h10
`define RTCAL_OFS_STATUS 5'h14
`define RTCAL_MASK_MONTH_DAY 16'h1f3f
`define RTCAL_MASK_WEEKDAY_HOURS 16'h073f
`define RTCAL_MASK_MINUTES_SECONDS 16'h7f7f
`define RTCAL_MASK_CONFIG_REPEAT 16'hfcff
`define RTCAL_MASK_CONFIG_CAL 16'h20ff
`define RTCAL_RESET_VALUE 16'h0000
`define RTCAL_BIT_ALARM_ENABLE 15
`define RTCAL_BIT_REPEAT_FOREVER 14
`define RTCAL_BIT_WRITE_ENABLE 13
`define RTCAL_CAL_SHIFT 2
`define RTCAL_RPT_MAX 8'hff
`define RTCAL_ALARM_INTERVAL_MASK_HALF_SEC 4'h0
`define RTCAL_ALARM_INTERVAL_MASK_SECOND 4'h1
`define RTCAL_ALARM_INTERVAL_MASK_TEN_SEC 4'h2
`define RTCAL_ALARM_INTERVAL_MASK_MINUTE 4'h3
`define RTCAL_ALARM_INTERVAL_MASK_TEN_MIN 4'h4
`define RTCAL_ALARM_INTERVAL_MASK_HOUR 4'h5
`define RTCAL_ALARM_INTERVAL_MASK_DAY 4'h6
`define RTCAL_ALARM_INTERVAL_MASK_WEEK 4'h7
`define RTCAL_ALARM_INTERVAL_MASK_MONTH 4'h8
`define RTCAL_ALARM_INTERVAL_MASK_YEAR 4'h9
`endif

/* design/rtcal_pkg.sv */
// Types shared by the alarm and calibration block.
// Assumes the time counters outside deliver the current time in this layout.
package rtcal_pkg;
    typedef struct packed {
        logic month_tens_digit;
        logic [3:0] month_ones_digit;
        logic [1:0] day_tens_digit;
        logic [3:0] day_ones_digit;
        logic [2:0] weekday_digit;
        logic [1:0] hour_tens_digit;
        logic [3:0] hour_ones_digit;
        logic [2:0] minute_tens_digit;
        logic [3:0] minute_ones_digit;
        logic [2:0] second_tens_digit;
        logic [3:0] second_ones_digit;
    } rtcal_time_t;

    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } rtcal_avs_req_t;

    typedef enum logic [1:0] {
        RTCAL_CAL_IDLE = 2'b01,
        RTCAL_CAL_RUN = 2'b10
    } rtcal_cal_state_t;

    typedef struct packed {
        logic [15:0] alarm_month_day;
        logic [15:0] alarm_weekday_hours;
        logic [15:0] alarm_minutes_seconds;
        logic [15:0] alarm_config_repeat;
        logic [15:0] clock_config_calibration;
        logic ack;
        logic [31:0] readdata;
        logic alarm_event;
        logic alarm_pulse;
        rtcal_cal_state_t cal_state;
        logic [9:0] cal_left;
        logic cal_negative;
        logic cal_add;
        logic cal_sub;
    } rtcal_state_t;
endpackage

/* verif/rtcal_asserts.sv */
// Concurrent checks on the ports of the alarm and calibration block.
// Assumes it is bound into rtcal_top and sees nothing but its ports.
`timescale 1ns/1ps
`default_nettype none
module rtcal_asserts
(
    input wire logic clk,
    input wire logic reset,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic half_sec_tick,
    input wire logic minute_tick,
    input wire logic alarm_irq,
    input wire logic alarm_pulse,
    input wire logic cal_add_pulse,
    input wire logic cal_sub_pulse
);
    // ----------------------------------------
    // Burst length counter
    // ----------------------------------------
    // A burst of calibration pulses must be a whole multiple of four long.
    logic [9:0] run_len;
    logic any_cal;
    assign any_cal = cal_add_pulse | cal_sub_pulse;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            run_len <= 10'h000;
        else if (any_cal)
            run_len <= run_len + 10'h001;
        else
            run_len <= 10'h000;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_irq_single: assert property (alarm_irq |=> !alarm_irq)
        else $error("alarm_irq high for more than one cycle");
    a_pulse_toggle: assert property ((alarm_pulse != $past(alarm_pulse)) == alarm_irq)
        else $error("alarm_pulse does not toggle exactly with alarm_irq");
    a_irq_tick: assert property (alarm_irq |-> $past(half_sec_tick))
        else $error("alarm_irq without a half second tick");
    a_add_start: assert property ($rose(cal_add_pulse) |-> $past(minute_tick, 2))
        else $error("add burst not two cycles after minute tick");
    a_sub_start: assert property ($rose(cal_sub_pulse) |-> $past(minute_tick, 2))
        else $error("sub burst not two cycles after minute tick");
    a_cal_excl: assert property (!(cal_add_pulse && cal_sub_pulse))
        else $error("add and sub pulses at once");
    a_burst_len: assert property ($fell(any_cal) |-> run_len[1:0] == 2'h0 && run_len <= 10'h200)
        else $error("calibration burst length not a multiple of four");
    a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_wait_once: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("waitrequest not exactly one cycle");
    c_alarm: cover property (alarm_irq);
    c_add: cover property ($rose(cal_add_pulse));
    c_sub: cover property ($rose(cal_sub_pulse));
endmodule // rtcal_asserts

bind rtcal_top rtcal_asserts u_chk (.clk(clk), .reset(reset), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .half_sec_tick(half_sec_tick), .minute_tick(minute_tick), .alarm_irq(alarm_irq),
    .alarm_pulse(alarm_pulse), .cal_add_pulse(cal_add_pulse), .cal_sub_pulse(cal_sub_pulse));
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench of the alarm and calibration block over Avalon-MM.
// Assumes rtcal_top and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    rtcal_pkg::rtcal_time_t time_now = '0;
    rtcal_pkg::rtcal_time_t base;
    logic half_sec_tick = 1'b0;
    logic second_tick = 1'b0;
    logic minute_tick = 1'b0;
    logic alarm_irq, alarm_pulse, cal_add_pulse, cal_sub_pulse;
    logic exp_pulse = 1'b0;
    logic [3:0] be = 4'h3;
    logic [31:0] d;
    int n_errors = 0;
    int cmp_count = 0;
    rtcal_top dut_u (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .time_now(time_now),
        .half_sec_tick(half_sec_tick), .second_tick(second_tick), .minute_tick(minute_tick),
        .alarm_irq(alarm_irq), .alarm_pulse(alarm_pulse), .cal_add_pulse(cal_add_pulse),
        .cal_sub_pulse(cal_sub_pulse));
    always #12.5 clk = ~clk;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic wrap_up();
        $display("mismatches %0d, comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Waitrequest is sampled at each rising edge; the edge that sees it low
    // is the one at which a write lands and read data is taken.
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] wd);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= wd;
        avs_byteenable <= be;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0)
        begin
            n_errors++;
            wrap_up();
        end
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        bus(a, 1'b1, {16'h0000, v});
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        bus(a, 1'b0, 32'h0);
        chk("readdata", d, {16'h0000, e});
    endtask
    task automatic fire(input rtcal_pkg::rtcal_time_t t, input logic st, input logic e);
        @(posedge clk);
        time_now <= t;
        half_sec_tick <= 1'b1;
        second_tick <= st;
        @(posedge clk);
        half_sec_tick <= 1'b0;
        second_tick <= 1'b0;
        #1;
        chk("alarm_irq", {31'h0, alarm_irq}, {31'h0, e});
        if (e)
            exp_pulse = ~exp_pulse;
        chk("alarm_pulse", {31'h0, alarm_pulse}, {31'h0, exp_pulse});
    endtask
    function automatic rtcal_pkg::rtcal_time_t pert(input int k);
        rtcal_pkg::rtcal_time_t t;
        t = base;
        case (k)
            1: t.second_ones_digit = 4'h9;
            2: t.second_tens_digit = 3'h4;
            3: t.minute_ones_digit = 4'h8;
            4: t.minute_tens_digit = 3'h4;
            5: t.hour_ones_digit = 4'h2;
            6: t.weekday_digit = 3'h4;
            7: t.day_ones_digit = 4'h0;
            8: t.month_ones_digit = 4'h1;
            default: ;
        endcase
        return t;
    endfunction
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] cv[4];
        int na, ns, ea, es;
        cv = '{8'h01, 8'hfe, 8'h80, 8'h7f};
        base = '{1'b1, 4'h2, 2'h3, 4'h1, 3'h3, 2'h2, 4'h3, 3'h5, 4'h9, 3'h5, 4'h8};
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        for (int a = 0; a < 6; a++)
            rdc(5'(a * 4), 16'h0000);
        wr(5'h18, 16'hffff);
        rdc(5'h18, 16'h0000);
        for (int a = 0; a < 3; a++)
            wr(5'(a * 4), 16'hffff);
        rdc(5'h00, 16'h0000);
        rdc(5'h04, 16'h0000);
        rdc(5'h08, 16'h7f7f);
        wr(5'h10, 16'h2000);
        wr(5'h00, 16'hffff);
        rdc(5'h00, 16'h1f3f);
        wr(5'h04, 16'hffff);
        rdc(5'h04, 16'h073f);
        be = 4'h1;
        wr(5'h08, 16'h0000);
        rdc(5'h08, 16'h7f00);
        be = 4'h3;
        // Alarm values are loaded with the alarm off, as software must.
        wr(5'h00, 16'h1231);
        wr(5'h04, 16'h0323);
        wr(5'h08, 16'h5958);
        // Configuration is written between ticks, never while the time steps.
        wr(5'h0c, 16'h8400);
        fire(base, 1'b1, 1'b1);
        rdc(5'h0c, 16'h0400);
        fire(base, 1'b1, 1'b0);
        wr(5'h0c, 16'h8402);
        for (int i = 0; i < 3; i++)
        begin
            fire(base, 1'b1, 1'b1);
            rdc(5'h0c, (i < 2) ? 16'(16'h8401 - i) : 16'h0400);
        end
        fire(base, 1'b1, 1'b0);
        wr(5'h0c, 16'h84ff);
        fire(base, 1'b1, 1'b1);
        rdc(5'h0c, 16'h84fe);
        wr(5'h0c, 16'hc400);
        fire(base, 1'b1, 1'b1);
        rdc(5'h0c, 16'hc4ff);
        for (int m = 0; m < 11; m++)
        begin
            wr(5'h0c, 16'hc000 | (16'(m) << 10));
            if (m == 0)
                fire(base, 1'b0, 1'b1);
            if (m == 1)
            begin
                fire(base, 1'b0, 1'b0);
                fire(pert(8), 1'b1, 1'b1);
            end
            if (m >= 2 && m <= 9)
            begin
                fire(pert(m - 1), 1'b1, 1'b0);
                fire(pert((m == 9) ? 0 : m), 1'b1, 1'b1);
            end
            if (m == 8)
                fire(pert(6), 1'b1, 1'b1);
            if (m == 10)
                fire(base, 1'b1, 1'b0);
        end
        bus(5'h14, 1'b0, 32'h0);
        chk("status", d & 32'h1, {31'h0, exp_pulse});
        wr(5'h0c, 16'h0000);
        for (int c = 0; c < 4; c++)
        begin
            // Calibration is changed only between bursts, with the timer idle.
            wr(5'h10, {8'h20, cv[c]});
            ea = cv[c][7] ? 0 : int'(cv[c]) * 4;
            es = cv[c][7] ? (256 - int'(cv[c])) * 4 : 0;
            // A burst that ends before the second minute tick runs again;
            // a long one makes that tick be refused.
            if (ea + es < 50)
            begin
                ea = ea * 2;
                es = es * 2;
            end
            na = 0;
            ns = 0;
            for (int i = 0; i < 560; i++)
            begin
                @(posedge clk);
                minute_tick <= (i == 0 || i == 50);
                #1;
                na += (cal_add_pulse === 1'b1);
                ns += (cal_sub_pulse === 1'b1);
            end
            chk("add pulses", 32'(na), 32'(ea));
            chk("sub pulses", 32'(ns), 32'(es));
        end
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
